/* hw/fwsr_host.sv */
// host that polls a nor flash's write-status bits and issues recovery resets
// assumes flash pins are synchronous to MCLK_I; dq is split into in/out/enable
//
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
// How it works
// R1 - device gives sector toggle after last strobe
// R2 - sector toggle inverts each read, erase sectors
// R3 - unselected sectors: toggle progress, steady sector bit
// R4 - host reads twice, compares toggle bits
// R5 - toggling with timeout high: recheck, then reset
// R6 - resumed monitoring restarts from first double read
// R7 - device sets timeout flag past limit
// R8 - program one over zero halts, times out
// R9 - after timeout host writes reset command
// R10 - erase window bit low during acceptance time
// R11 - fast hosts may skip window monitoring
// R12 - window high means later commands ignored
// R13 - read window bit around added sector erase
// R14 - erasing sector: both toggle bits toggle
// R15 - suspended sector: polling one, sector bit toggles
// R16 - host addresses the busy bank for status
// R17 - host places valid operation address
// R18 - status driven only with strobes asserted
module fwsr_host
   import fwsr_pkg::*;
(
   // clock, reset, enable
   input  wire logic                     MCLK_I,
   input  wire logic                     RESET_I,
   input  wire logic                     CE_I,
   // avalon-mm slave
   input  wire logic [3:0]               AVS_ADDRESS_I,
   input  wire logic                     AVS_READ_I,
   input  wire logic                     AVS_WRITE_I,
   input  wire logic [31:0]              AVS_WRITEDATA_I,
   output logic      [31:0]              AVS_READDATA_O,
   output logic                          AVS_WAITREQUEST_O,
   output logic                          IRQ_O,
   // flash pins
   output logic                          FL_CE_N_O,
   output logic                          FL_OE_N_O,
   output logic                          FL_WE_N_O,
   output logic      [fwsr_pkg::ADDR_W-1:0] FL_ADDR_O,
   output logic      [fwsr_pkg::DATA_W-1:0] FL_DQ_O,
   output logic                          FL_DQ_OE_O,
   input  wire logic [fwsr_pkg::DATA_W-1:0] FL_DQ_I,
   input  wire logic                     FL_READY_BUSY_I
);
   import fwsr_pkg::*;

   fwsr_state_t       state_reg, state_next;
   fwsr_pins_t        pins_reg;
   logic [3:0]        cnt_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] first_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [2:0]        result_reg;
   logic              win_reg;
   logic              sec_reg;
   logic              autorst_reg;
   logic              fail_pend_reg;
   logic [EV_N-1:0]   stat_reg;
   logic [EV_N-1:0]   mask_reg;
   logic [EV_N-1:0]   ev_set;
   logic              ack_reg;

   // bus decode
   wire       acc     = AVS_READ_I | AVS_WRITE_I;
   wire       wr_take = CE_I & AVS_WRITE_I & ~ack_reg;
   wire       rd_take = CE_I & AVS_READ_I & ~ack_reg;
   wire       busy    = (state_reg != ST_IDLE);
   wire       wr_ctrl = wr_take & (AVS_ADDRESS_I == REG_CTRL) & ~busy;
   wire       go_poll = wr_ctrl & AVS_WRITEDATA_I[CTRL_POLL];
   wire       go_wr   = wr_ctrl & (AVS_WRITEDATA_I[CTRL_WRITE] | AVS_WRITEDATA_I[CTRL_RST]);
   wire       go_rd   = wr_ctrl & AVS_WRITEDATA_I[CTRL_READ];
   wire       tmr_end = (cnt_reg == CNT_ZERO);
   wire [DATA_W-1:0] dq = FL_DQ_I;
   // progress bit (or sector bit when sector mode is set) differs between reads
   wire       tog_p   = first_reg[BIT_PROG] ^ dq[BIT_PROG];
   wire       tog_s   = first_reg[BIT_SECT] ^ dq[BIT_SECT];
   wire       toggling = sec_reg ? tog_s : tog_p;
   wire       tmo_hi  = dq[BIT_TMO];
   wire       pin_ready = FL_READY_BUSY_I;

   function automatic logic [31:0] rd_mux(input logic [3:0] a);
      case (a)
         REG_CTRL:   rd_mux = {26'h0, autorst_reg, sec_reg, 3'h0, busy};
         REG_ADDR:   rd_mux = {10'h0, addr_reg};
         REG_WDATA:  rd_mux = {16'h0, wdata_reg};
         REG_RESULT: rd_mux = {26'h0, pin_ready, win_reg, 1'b0, result_reg};
         REG_STAT:   rd_mux = {29'h0, stat_reg};
         REG_MASK:   rd_mux = {29'h0, mask_reg};
         REG_RDATA:  rd_mux = {16'h0, rdata_reg};
         default:    rd_mux = 32'h0;
      endcase
   endfunction

   assign AVS_WAITREQUEST_O = acc & ~ack_reg;
   assign IRQ_O             = |(stat_reg & mask_reg);
   assign FL_CE_N_O  = pins_reg.ce_n;
   assign FL_OE_N_O  = pins_reg.oe_n;
   assign FL_WE_N_O  = pins_reg.we_n;
   assign FL_ADDR_O  = pins_reg.addr;
   assign FL_DQ_O    = pins_reg.dout;
   assign FL_DQ_OE_O = pins_reg.doe;

   // sequencer
   always_comb begin
      state_next = state_reg;
      ev_set     = '0;
      case (state_reg)
         ST_IDLE: begin
            if (go_poll) state_next = ST_RD1; // R6
            else if (go_wr) state_next = ST_WR;
            else if (go_rd) state_next = ST_RDARR;
         end
         ST_RD1: if (tmr_end) state_next = ST_GAP;
         ST_GAP: state_next = ST_RD2;
         ST_RD2: begin
            if (tmr_end) begin
               if (!toggling) state_next = ST_RESULT; // R4
               else if (tmo_hi) state_next = ST_RD3; // R5
               else state_next = ST_RD4;
            end
         end
         ST_RD3: if (tmr_end) state_next = ST_RD4;
         ST_RD4: if (tmr_end) state_next = ST_RESULT;
         ST_WR:  if (tmr_end) state_next = ST_RESULT;
         ST_RDARR: if (tmr_end) state_next = ST_RESULT;
         ST_RESULT: begin
            state_next = ST_IDLE;
            if (result_reg == RES_OK) ev_set[EV_DONE] = 1'b1;
            if (result_reg == RES_FAIL) ev_set[EV_FAIL] = 1'b1;
            if (result_reg == RES_SHUT) ev_set[EV_ACC] = 1'b1;
            // failure with auto recovery goes straight to the reset write
            if (fail_pend_reg && autorst_reg) state_next = ST_WR; // R9
         end
         default: state_next = ST_IDLE;
      endcase
   end

   wire enter_rd = (state_next == ST_RD1 || state_next == ST_RD2 ||
                    state_next == ST_RD3 || state_next == ST_RD4 ||
                    state_next == ST_RDARR) && (state_next != state_reg);
   wire enter_wr = (state_next == ST_WR) && (state_reg != ST_WR);
   wire reading  = (state_next == ST_RD1 || state_next == ST_RD2 ||
                    state_next == ST_RD3 || state_next == ST_RD4 ||
                    state_next == ST_RDARR);
   // only the recovery path or an explicit reset order writes the reset command;
   // a failure left pending from an earlier poll must not replace a plain write
   wire [DATA_W-1:0] wr_val = (state_reg == ST_RESULT || AVS_WRITEDATA_I[CTRL_RST])
                              ? CMD_RESET : wdata_reg;

   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         state_reg <= ST_IDLE;
         cnt_reg   <= CNT_ZERO;
         pins_reg  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dout: '0, doe: 1'b0};
      end else if (CE_I) begin
         state_reg <= state_next;
         if (enter_rd) cnt_reg <= ACC_CNT;
         else if (enter_wr) cnt_reg <= WP_CNT;
         else if (!tmr_end) cnt_reg <= cnt_reg - 4'h1;
         // each status read is a separate strobe so the device steps its toggles
         pins_reg.ce_n <= ~(reading | (state_next == ST_WR)); // R16
         // first cycle of every read keeps oe high, so back to back reads are distinct
         pins_reg.oe_n <= ~reading | enter_rd; // R5
         pins_reg.we_n <= ~(state_next == ST_WR);
         pins_reg.doe  <= (state_next == ST_WR);
         pins_reg.addr <= addr_reg; // R17
         if (enter_wr) pins_reg.dout <= wr_val; // R9
      end
   end

   // sampled data and verdict
   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         first_reg     <= '0;
         rdata_reg     <= '0;
         result_reg    <= RES_NONE;
         win_reg       <= 1'b0;
         fail_pend_reg <= 1'b0;
      end else if (CE_I) begin
         if (go_poll || go_rd || go_wr) begin
            result_reg <= RES_NONE;
            fail_pend_reg <= 1'b0;
         end
         if (tmr_end && state_reg != ST_IDLE && state_reg != ST_GAP &&
             state_reg != ST_RESULT && state_reg != ST_WR) begin
            first_reg <= dq;
            rdata_reg <= dq;
         end
         if (tmr_end && state_reg == ST_RD1) win_reg <= dq[BIT_WIN]; // R13
         if (tmr_end && state_reg == ST_RD2 && !toggling) begin
            // R11
            result_reg <= sec_reg ? (dq[BIT_WIN] ? RES_SHUT : RES_OPEN) : RES_OK;
            win_reg <= dq[BIT_WIN]; // R12
         end
         if (tmr_end && state_reg == ST_RD2 && toggling && !tmo_hi) result_reg <= RES_NONE;
         if (tmr_end && state_reg == ST_RD3) begin
            result_reg    <= toggling ? RES_FAIL : RES_OK; // R5
            fail_pend_reg <= toggling;
         end
         if (tmr_end && state_reg == ST_RDARR) result_reg <= RES_OK;
         if (state_reg == ST_RESULT && state_next == ST_WR) fail_pend_reg <= 1'b0;
      end
   end

   // registers and bus answer
   always_ff @(posedge MCLK_I or posedge RESET_I) begin
      if (RESET_I) begin
         addr_reg       <= '0;
         wdata_reg      <= '0;
         sec_reg        <= 1'b0;
         autorst_reg    <= 1'b0;
         stat_reg       <= '0;
         mask_reg       <= '0;
         ack_reg        <= 1'b0;
         AVS_READDATA_O <= 32'h0;
      end else if (CE_I) begin
         ack_reg <= acc & ~ack_reg;
         if (rd_take) AVS_READDATA_O <= rd_mux(AVS_ADDRESS_I);
         if (wr_take && AVS_ADDRESS_I == REG_ADDR && !busy) addr_reg <= AVS_WRITEDATA_I[ADDR_W-1:0];
         if (wr_take && AVS_ADDRESS_I == REG_WDATA && !busy) wdata_reg <= AVS_WRITEDATA_I[DATA_W-1:0];
         if (wr_ctrl) begin
            sec_reg     <= AVS_WRITEDATA_I[CTRL_SEC];
            autorst_reg <= AVS_WRITEDATA_I[CTRL_AUTORST];
         end
         if (wr_take && AVS_ADDRESS_I == REG_MASK) mask_reg <= AVS_WRITEDATA_I[EV_N-1:0];
         // set wins over write-one-to-clear
         if (wr_take && AVS_ADDRESS_I == REG_STAT)
            stat_reg <= (stat_reg & ~AVS_WRITEDATA_I[EV_N-1:0]) | ev_set;
         else
            stat_reg <= stat_reg | ev_set;
      end
   end

   chk_read_strobes: assert property (@(posedge MCLK_I) disable iff (RESET_I) // R18
      (!FL_OE_N_O |-> !FL_CE_N_O && FL_WE_N_O && !FL_DQ_OE_O))
      else $error("oe asserted without ce or during write");
   chk_double_read: assert property (@(posedge MCLK_I) disable iff (RESET_I) // R4
      (state_reg == ST_RD2 && tmr_end && CE_I |-> $past(state_reg) == ST_RD2 || $past(state_reg) == ST_GAP))
      else $error("compare without preceding read");
   chk_fail_recheck: assert property (@(posedge MCLK_I) disable iff (RESET_I) // R5
      (CE_I && state_reg == ST_RD2 && tmr_end && toggling && tmo_hi |=> state_reg == ST_RD3))
      else $error("timeout without recheck");
   chk_restart_poll: assert property (@(posedge MCLK_I) disable iff (RESET_I) // R6
      (CE_I && state_reg == ST_IDLE && go_poll |=> state_reg == ST_RD1))
      else $error("poll did not start from first read");
   chk_reset_cmd: assert property (@(posedge MCLK_I) disable iff (RESET_I) // R9
      (CE_I && state_reg == ST_RESULT && fail_pend_reg && autorst_reg
       |=> ##1 !FL_WE_N_O && FL_DQ_O == CMD_RESET))
      else $error("no reset command after failure");
   chk_gap_strobe: assert property (@(posedge MCLK_I) disable iff (RESET_I) // R18
      (CE_I && state_reg == ST_GAP |-> FL_OE_N_O))
      else $error("reads not separated");
   chk_addr_held: assert property (@(posedge MCLK_I) disable iff (RESET_I) // R17
      (!FL_OE_N_O && busy |-> FL_ADDR_O == addr_reg))
      else $error("status read off target address");
   chk_fail_event: assert property (@(posedge MCLK_I) disable iff (RESET_I) // R5
      (CE_I && state_reg == ST_RESULT && result_reg == RES_FAIL |=> stat_reg[EV_FAIL]))
      else $error("failure not recorded in status");
   chk_read_gap: assert property (@(posedge MCLK_I) disable iff (RESET_I) // R5
      (CE_I && enter_rd |=> FL_OE_N_O))
      else $error("new read started without strobe gap");
endmodule

/* hw/fwsr_pkg.sv */
// package for the flash write status poller: register map, pin timing, states
// assumes a 32-bit avalon-mm slave port and an async parallel nor flash outside
package fwsr_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   // register word offsets (byte address / 4)
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h1;
   localparam logic [3:0] REG_WDATA  = 4'h2;
   localparam logic [3:0] REG_RESULT = 4'h3;
   localparam logic [3:0] REG_STAT   = 4'h4;
   localparam logic [3:0] REG_MASK   = 4'h5;
   localparam logic [3:0] REG_RDATA  = 4'h6;
   // ctrl bits
   localparam int CTRL_POLL  = 0;
   localparam int CTRL_WRITE = 1;
   localparam int CTRL_READ  = 2;
   localparam int CTRL_RST   = 3;
   localparam int CTRL_SEC   = 4;
   localparam int CTRL_AUTORST = 5;
   // event bits
   localparam int EV_DONE = 0;
   localparam int EV_FAIL = 1;
   localparam int EV_ACC  = 2;
   localparam int EV_N    = 3;
   // status bit positions on the data bus
   localparam int BIT_POLL   = 7;
   localparam int BIT_PROG   = 6;
   localparam int BIT_TMO    = 5;
   localparam int BIT_WIN    = 3;
   localparam int BIT_SECT   = 2;
   // result codes
   localparam logic [2:0] RES_NONE  = 3'h0;
   localparam logic [2:0] RES_OK    = 3'h1;
   localparam logic [2:0] RES_FAIL  = 3'h2;
   localparam logic [2:0] RES_OPEN  = 3'h3;
   localparam logic [2:0] RES_SHUT  = 3'h4;
   // reset command written to any address
   localparam logic [15:0] CMD_RESET = 16'h00F0;
   // pin timing
   localparam int CLK_PS = 25000;
   localparam int T_ACC_NS = 70;
   localparam int T_WP_NS  = 35;
   localparam int ACC_CYC = (T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam int WP_CYC  = (T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS;
   localparam logic [3:0] ACC_CNT = 4'(ACC_CYC);
   localparam logic [3:0] WP_CNT  = 4'(WP_CYC);
   localparam logic [3:0] CNT_ZERO = 4'h0;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000,
      ST_RD1    = 4'b0001,
      ST_RD2    = 4'b0010,
      ST_RD3    = 4'b0011,
      ST_RD4    = 4'b0100,
      ST_WR     = 4'b0101,
      ST_RESULT = 4'b0110,
      ST_RDARR  = 4'b0111,
      ST_GAP    = 4'b1000
   } fwsr_state_t;

   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dout;
      logic              doe;
   } fwsr_pins_t;
endpackage

/* verif/fwsr_flash_model.sv */
// behavioural nor flash status model: toggle, timeout, window, ready pin
// assumes host strobes as in the host pin contract; go_i starts a chosen status mode
`timescale 1ns/1ps
module fwsr_flash_model
   import fwsr_pkg::*;
(
   // flash pins from the host
   input  wire logic                        ce_n_i,
   input  wire logic                        oe_n_i,
   input  wire logic                        we_n_i,
   input  wire logic [fwsr_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [fwsr_pkg::DATA_W-1:0] dq_i,
   input  wire logic                        dq_oe_i,
   // scenario control: op 1 erase, 2 erase past limit, 3 suspended
   input  wire logic                        go_i,
   input  wire logic [1:0]                  op_i,
   input  wire logic                        win_i,
   // flash outputs
   output logic      [fwsr_pkg::DATA_W-1:0] dq_o,
   output logic                             ready_busy_o
);
   import fwsr_pkg::*;
   logic [1:0]        op_reg = 2'h0;
   logic              tog_reg = 1'b0;
   logic [DATA_W-1:0] last_reg = 16'h0000;
   logic [DATA_W-1:0] wdat_reg = 16'h0000;
   logic [DATA_W-1:0] array_w;
   logic [DATA_W-1:0] stat_w;
   logic [DATA_W-1:0] cur_w;
   wire               rd_n_w = ce_n_i | oe_n_i;
   wire               sel_w = addr_i[21];
   wire               erasing_w = (op_reg == 2'h1) || (op_reg == 2'h2);
   assign array_w = addr_i[15:0] ^ 16'hA5C3;
   // latch write data while the strobe is low, so the strobe edge sees it
   always @(we_n_i or dq_oe_i or dq_i) begin
      if (!we_n_i && dq_oe_i) wdat_reg = dq_i;
   end
   always @(posedge go_i or posedge we_n_i) begin
      if (go_i) op_reg <= op_i;
      else if (wdat_reg == CMD_RESET) op_reg <= 2'h0;
   end
   // one toggle step per completed read strobe
   always @(posedge rd_n_w) begin
      last_reg <= cur_w;
      tog_reg  <= ~tog_reg;
   end
   always_comb begin
      stat_w = array_w;
      if (erasing_w) begin
         stat_w = 16'h0000;
         stat_w[BIT_PROG] = tog_reg;
         stat_w[BIT_TMO]  = (op_reg == 2'h2);
         stat_w[BIT_WIN]  = win_i;
         stat_w[BIT_SECT] = sel_w & tog_reg;
      end else if (op_reg == 2'h3 && sel_w) begin
         stat_w = 16'h0000;
         stat_w[BIT_POLL] = 1'b1;
         stat_w[BIT_SECT] = tog_reg;
      end
   end
   assign cur_w = addr_i[20] ? array_w : stat_w;
   // released bus shows the inverse of the last value
   assign dq_o = rd_n_w ? ~last_reg : cur_w;
   assign ready_busy_o = ~erasing_w;
endmodule

/* verif/tb_top.sv */
// self-checking bench for the flash status poller over avalon-mm
// assumes the flash model answers on the host pins; expected reads queue up
`timescale 1ns/1ps
module tb_top;
   import fwsr_pkg::*;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic [3:0]        av_addr = 4'h0;
   logic              av_rd = 1'b0;
   logic              av_wr = 1'b0;
   logic [31:0]       av_wd = 32'h0;
   logic [31:0]       av_q;
   logic              av_wait;
   logic              irq;
   logic              fl_ce_n, fl_oe_n, fl_we_n, fl_doe, fl_rb;
   logic [ADDR_W-1:0] fl_addr;
   logic [DATA_W-1:0] fl_dout, fl_din;
   logic              go = 1'b0;
   logic [1:0]        op = 2'h0;
   logic              win = 1'b0;
   logic [63:0]       exp_q[$];
   logic [63:0]       e;
   logic [31:0]       rv;
   logic [21:0]       a;
   int                miscompares = 0;
   int                n_tests = 0;
   always #12.5 clk = ~clk;
   fwsr_host dut_u (.MCLK_I(clk), .RESET_I(rst), .CE_I(1'b1), .AVS_ADDRESS_I(av_addr),
      .AVS_READ_I(av_rd), .AVS_WRITE_I(av_wr), .AVS_WRITEDATA_I(av_wd),
      .AVS_READDATA_O(av_q), .AVS_WAITREQUEST_O(av_wait), .IRQ_O(irq),
      .FL_CE_N_O(fl_ce_n), .FL_OE_N_O(fl_oe_n), .FL_WE_N_O(fl_we_n), .FL_ADDR_O(fl_addr),
      .FL_DQ_O(fl_dout), .FL_DQ_OE_O(fl_doe), .FL_DQ_I(fl_din), .FL_READY_BUSY_I(fl_rb));
   fwsr_flash_model flash_u (.ce_n_i(fl_ce_n), .oe_n_i(fl_oe_n), .we_n_i(fl_we_n),
      .addr_i(fl_addr), .dq_i(fl_dout), .dq_oe_i(fl_doe), .go_i(go), .op_i(op),
      .win_i(win), .dq_o(fl_din), .ready_busy_o(fl_rb));
   // read results are compared at the edge where they are taken
   always @(posedge clk) begin
      if (av_rd && av_wait === 1'b0 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e[31:0] != 32'h0) begin
            n_tests++;
            if ((av_q & e[31:0]) !== e[63:32]) begin
               miscompares++;
               $display("MISMATCH %0t reg %0d got %h want %h", $time, av_addr, av_q, e[63:32]);
            end
         end
      end
   end
   task automatic close_out;
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bus(input logic [3:0] ad, input logic w, input logic [31:0] d,
                      input logic [31:0] ex, input logic [31:0] m);
      int n;
      if (!w) exp_q.push_back({ex & m, m});
      @(posedge clk);
      av_addr <= ad;
      av_wr <= w;
      av_rd <= !w;
      av_wd <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (av_wait !== 1'b0 && n < 50);
      if (n >= 50) miscompares++;
      rv = av_q;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask
   task automatic wait_idle;
      int k;
      k = 0;
      do begin
         bus(REG_CTRL, 1'b0, 32'h0, 32'h0, 32'h0);
         k++;
      end while (rv[0] !== 1'b0 && k < 300);
      if (k >= 300) miscompares++;
   endtask
   task automatic start(input logic [1:0] o, input logic wn);
      @(posedge clk);
      op <= o;
      win <= wn;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask
   task automatic poll(input logic [31:0] c, input logic [31:0] ex, input logic [31:0] m);
      bus(REG_CTRL, 1'b1, c, 32'h0, 32'h0);
      wait_idle();
      bus(REG_RESULT, 1'b0, 32'h0, ex, m);
   endtask
   task automatic chk_irq(input logic want);
      repeat (3) @(posedge clk);
      n_tests++;
      if (irq !== want) begin
         miscompares++;
         $display("MISMATCH %0t irq %b", $time, irq);
      end
   endtask
   initial begin
      #500000;
      miscompares++;
      close_out();
   end
   initial begin
      rv = $urandom(6728);
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      bus(REG_STAT, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF);
      bus(REG_MASK, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF);
      bus(4'h7, 1'b1, 32'hFFFFFFFF, 32'h0, 32'h0);
      bus(4'h7, 1'b0, 32'h0, 32'h0, 32'hFFFFFFFF);
      a = {2'b10, 20'($urandom()) & 20'h0FFFF};
      bus(REG_ADDR, 1'b1, 32'(a), 32'h0, 32'h0);
      poll(32'h01, 32'h21, 32'h27);
      start(2'h1, 1'b0);
      poll(32'h01, 32'h00, 32'h37);
      poll(32'h11, 32'h00, 32'h37);
      bus(REG_ADDR, 1'b1, 32'(a & 22'h1FFFFF), 32'h0, 32'h0);
      poll(32'h11, 32'h03, 32'h37);
      bus(REG_ADDR, 1'b1, 32'(a), 32'h0, 32'h0);
      start(2'h1, 1'b1);
      poll(32'h01, 32'h10, 32'h37);
      bus(REG_ADDR, 1'b1, 32'(a & 22'h1FFFFF), 32'h0, 32'h0);
      poll(32'h11, 32'h04, 32'h27);
      bus(REG_ADDR, 1'b1, 32'(a | 22'h100000), 32'h0, 32'h0);
      poll(32'h01, 32'h01, 32'h27);
      bus(REG_ADDR, 1'b1, 32'(a), 32'h0, 32'h0);
      start(2'h3, 1'b0);
      poll(32'h01, 32'h21, 32'h27);
      poll(32'h11, 32'h20, 32'h27);
      bus(REG_MASK, 1'b1, 32'h2, 32'h0, 32'h0);
      start(2'h2, 1'b1);
      poll(32'h21, 32'h02, 32'h07);
      bus(REG_STAT, 1'b0, 32'h0, 32'h2, 32'h2);
      chk_irq(1'b1);
      bus(REG_STAT, 1'b1, 32'h7, 32'h0, 32'h0);
      chk_irq(1'b0);
      poll(32'h01, 32'h21, 32'h27);
      start(2'h2, 1'b0);
      poll(32'h01, 32'h02, 32'h27);
      bus(REG_WDATA, 1'b1, 32'(16'($urandom()) | 16'h0100), 32'h0, 32'h0);
      bus(REG_CTRL, 1'b1, 32'h02, 32'h0, 32'h0);
      wait_idle();
      poll(32'h01, 32'h02, 32'h27);
      bus(REG_CTRL, 1'b1, 32'h08, 32'h0, 32'h0);
      wait_idle();
      poll(32'h01, 32'h21, 32'h27);
      for (int i = 0; i < 3; i++) begin
         a = 22'($urandom());
         bus(REG_ADDR, 1'b1, 32'(a), 32'h0, 32'h0);
         bus(REG_CTRL, 1'b1, 32'h04, 32'h0, 32'h0);
         wait_idle();
         bus(REG_RDATA, 1'b0, 32'h0, 32'(a[15:0] ^ 16'hA5C3), 32'hFFFF);
      end
      close_out();
   end
endmodule
